/* verilog/smcc_pkg.sv */
// Package for the serializer mode and clock configuration register group.
// Assumes a byte-wide register port with 8-bit offsets; one clock, synchronous reset.
package smcc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_OPERATING_MODE_SELECT = 8'h03;
    localparam logic [7:0] OFS_PARALLEL_MODE_SELECT = 8'h04;
    localparam logic [7:0] OFS_REFERENCE_CLOCK_CONTROL = 8'h05;
    localparam logic [7:0] OFS_OUTPUT_CLOCK_CONTROL_LOW = 8'h06;
    localparam logic [7:0] OFS_OUTPUT_CLOCK_CONTROL_HIGH = 8'h07;
    // ==========================================================
    // Field positions
    localparam int MODE_LSB = 0;
    localparam int MODE_DONE_BIT = 3;
    localparam int MODE_OVERRIDE_SELECT_BIT = 4;
    localparam int RAW10_BIT = 2;
    localparam int RAW12_BIT = 1;
    localparam int PROTECT_BIT = 0;
    localparam int CLKDIV_LSB = 4;
    localparam int OSC_BIT = 3;
    localparam int HSDIV_LSB = 5;
    localparam int MVAL_LSB = 0;
    // ==========================================================
    // Reset values
    localparam logic [2:0] HSDIV_RESET = 3'h2;
    localparam logic [4:0] MVAL_RESET = 5'h01;
    localparam logic [7:0] NVAL_RESET = 8'h28;
    localparam logic [2:0] CLKDIV_RESET = 3'h0;
    localparam logic [2:0] REFCTL_RSVD_RESET = 3'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ==========================================================
    // Operating modes
    typedef enum logic [2:0] {
        SMCC_MODE_SYNC = 3'h0,
        SMCC_MODE_RSVD = 3'h1,
        SMCC_MODE_NSYNC_EXT = 3'h2,
        SMCC_MODE_NSYNC_INT = 3'h3,
        SMCC_MODE_PAR_EXT = 3'h5
    } smcc_mode_e;
    // ==========================================================
    // Strap capture sequencer, one-hot
    typedef enum logic [2:0] {
        SMCC_ST_DOWN = 3'b001,
        SMCC_ST_LATCH = 3'b010,
        SMCC_ST_DONE = 3'b100
    } smcc_state_e;
    // ==========================================================
    // Register write request
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } smcc_wreq_s;
    // Clock configuration seen by the clocking logic
    typedef struct packed {
        logic [2:0] in_div_log2;
        logic       osc_range;
        logic       use_osc;
        logic [4:0] hs_div_log2;
        logic [4:0] m_val;
        logic [7:0] n_val;
        logic       out_clk_en;
    } smcc_clkcfg_s;
endpackage

/* verilog/smcc_top.sv */
// Mode and clock configuration register group of a camera-link serializer.
// Assumes a byte register port shared by the local I2C target and the control
// channel, already arbitrated; the strap is stable while the power-down pin is low.
// ==========================================================
// Summary of operation
// - Mode field shows active mode, writable when overridden
// - Strap captured on power-down pin rising edge
// - Mode codes select sync, nonsync, parallel operation
// - Done bit set once mode latched
// - Override bit picks register over strap
// - Control channel sets RAW10 bit on lock
// - Control channel sets RAW12 bit on lock
// - Protect bit blocks channel auto-load
// - Input clock divided by 1,2,4,8
// - Oscillator used when internal or no clock
// - High-speed divider 1 to 16, reset 4
// - Output clock scaled by M over N
// - M zero stops the output clock
// - N divisor eight bits, reset 0x28, nonzero; a write of zero is accepted and passed on
module smcc_top
    import smcc_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // Pins
    input wire logic POWERDOWN_ACTIVE_LOW_PIN_N,
    input wire logic [2:0] MODE_STRAP,
    input wire logic EXT_CLK_DETECTED,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Control channel auto-load
    input wire logic CHAN_RX_LOCK,
    input wire logic CHAN_RAW10,
    input wire logic CHAN_RAW12,
    // Configuration outputs
    output logic [2:0] ACTIVE_MODE,
    output logic MODE_DONE,
    output logic RAW10_PARALLEL_MODE_BIT,
    output logic RAW12_PARALLEL_MODE_BIT,
    output smcc_clkcfg_s CLK_CFG
);
    // ==========================================================
    // Register state
    smcc_state_e st_q, st_d;             // Strap capture sequencer
    logic pdb_q, pdb_d;                  // Previous power-down pin level
    logic [2:0] strap_q, strap_d;        // Latched strap mode
    logic [2:0] regmode_q, regmode_d;    // Software mode value
    logic ov_q, ov_d;                    // Mode override
    logic rsv0_q, rsv0_d;                // Reserved r/w bits 7 and 5
    logic rsv1_q, rsv1_d;
    logic raw10_q, raw10_d;
    logic raw12_q, raw12_d;
    logic prot_q, prot_d;
    logic [4:0] bcrsv_q, bcrsv_d;        // Reserved bits 7:3 of parallel select
    logic refrsv7_q, refrsv7_d;
    logic [2:0] clkdiv_q, clkdiv_d;
    logic osc_q, osc_d;
    logic [2:0] refrsv_q, refrsv_d;
    logic [2:0] hsdiv_q, hsdiv_d;
    logic [4:0] mval_q, mval_d;
    logic [7:0] nval_q, nval_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [2:0] act_q, act_d;
    logic done_q, done_d;
    smcc_clkcfg_s cfg_q, cfg_d;
    smcc_wreq_s wreq;
    logic [2:0] mode_now;

    assign wreq = '{wr: REG_WR, addr: REG_ADDR, data: REG_WDATA};
    // Active mode: override picks software value, else strap
    assign mode_now = ov_q ? regmode_q : strap_q;

    // ==========================================================
    // Strap capture sequencer
    // Capture only on the low-to-high pin edge, so the strap can't drift later
    always_comb
    begin
        st_d = st_q;
        strap_d = strap_q;
        pdb_d = POWERDOWN_ACTIVE_LOW_PIN_N;
        case (st_q)
            SMCC_ST_DOWN:
            begin
                // Edge of the pin takes the strap
                if (POWERDOWN_ACTIVE_LOW_PIN_N && !pdb_q)
                begin
                    strap_d = MODE_STRAP;
                    st_d = SMCC_ST_LATCH;
                end
            end
            SMCC_ST_LATCH:
                st_d = SMCC_ST_DONE;
            SMCC_ST_DONE:
            begin
                // Power-down again: wait for next rising edge
                if (!POWERDOWN_ACTIVE_LOW_PIN_N)
                    st_d = SMCC_ST_DOWN;
            end
            default:
                st_d = SMCC_ST_DOWN;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            st_q <= SMCC_ST_DOWN;
            pdb_q <= 1'b0;
            strap_q <= 3'h0;
        end
        else
        begin
            st_q <= st_d;
            pdb_q <= pdb_d;
            strap_q <= strap_d;
        end
    end

    // ==========================================================
    // Register writes and channel auto-load
    always_comb
    begin
        regmode_d = regmode_q;
        ov_d = ov_q;
        rsv0_d = rsv0_q;
        rsv1_d = rsv1_q;
        raw10_d = raw10_q;
        raw12_d = raw12_q;
        prot_d = prot_q;
        bcrsv_d = bcrsv_q;
        refrsv7_d = refrsv7_q;
        clkdiv_d = clkdiv_q;
        osc_d = osc_q;
        refrsv_d = refrsv_q;
        hsdiv_d = hsdiv_q;
        mval_d = mval_q;
        nval_d = nval_q;
        // Keep the software copy tracking the strap while not overridden,
        // so setting override keeps the mode stable
        if (!ov_q)
            regmode_d = strap_q;
        // Channel loads parallel bits after lock unless protected
        if (CHAN_RX_LOCK && !prot_q)
        begin
            raw10_d = CHAN_RAW10;
            raw12_d = CHAN_RAW12;
        end
        if (wreq.wr)
        begin
            case (wreq.addr)
                OFS_OPERATING_MODE_SELECT:
                begin
                    ov_d = wreq.data[MODE_OVERRIDE_SELECT_BIT];
                    rsv1_d = wreq.data[7];
                    rsv0_d = wreq.data[5];
                    // Mode writable only while overridden
                    if (ov_q)
                        regmode_d = wreq.data[MODE_LSB +: 3];
                end
                OFS_PARALLEL_MODE_SELECT:
                begin
                    // Software write wins over channel load in the same cycle
                    raw10_d = wreq.data[RAW10_BIT];
                    raw12_d = wreq.data[RAW12_BIT];
                    prot_d = wreq.data[PROTECT_BIT];
                    bcrsv_d = wreq.data[7:3];
                end
                OFS_REFERENCE_CLOCK_CONTROL:
                begin
                    refrsv7_d = wreq.data[7];
                    clkdiv_d = wreq.data[CLKDIV_LSB +: 3];
                    osc_d = wreq.data[OSC_BIT];
                    refrsv_d = wreq.data[2:0];
                end
                OFS_OUTPUT_CLOCK_CONTROL_LOW:
                begin
                    hsdiv_d = wreq.data[HSDIV_LSB +: 3];
                    mval_d = wreq.data[MVAL_LSB +: 5];
                end
                OFS_OUTPUT_CLOCK_CONTROL_HIGH:
                    nval_d = wreq.data;
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            regmode_q <= 3'h0;
            ov_q <= 1'b0;
            rsv0_q <= 1'b0;
            rsv1_q <= 1'b0;
            raw10_q <= 1'b0;
            raw12_q <= 1'b0;
            prot_q <= 1'b0;
            bcrsv_q <= 5'h00;
            refrsv7_q <= 1'b0;
            clkdiv_q <= CLKDIV_RESET;
            osc_q <= 1'b0;
            refrsv_q <= REFCTL_RSVD_RESET;
            hsdiv_q <= HSDIV_RESET;
            mval_q <= MVAL_RESET;
            nval_q <= NVAL_RESET;
        end
        else
        begin
            regmode_q <= regmode_d;
            ov_q <= ov_d;
            rsv0_q <= rsv0_d;
            rsv1_q <= rsv1_d;
            raw10_q <= raw10_d;
            raw12_q <= raw12_d;
            prot_q <= prot_d;
            bcrsv_q <= bcrsv_d;
            refrsv7_q <= refrsv7_d;
            clkdiv_q <= clkdiv_d;
            osc_q <= osc_d;
            refrsv_q <= refrsv_d;
            hsdiv_q <= hsdiv_d;
            mval_q <= mval_d;
            nval_q <= nval_d;
        end
    end

    // ==========================================================
    // Read data, status and clock configuration outputs
    always_comb
    begin
        rvalid_d = REG_RD;
        rdata_d = rdata_q;
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_OPERATING_MODE_SELECT:
                    rdata_d = {rsv1_q, 1'b0, rsv0_q, ov_q, done_q, mode_now};
                OFS_PARALLEL_MODE_SELECT:
                    rdata_d = {bcrsv_q, raw10_q, raw12_q, prot_q};
                OFS_REFERENCE_CLOCK_CONTROL:
                    rdata_d = {refrsv7_q, clkdiv_q, osc_q, refrsv_q};
                OFS_OUTPUT_CLOCK_CONTROL_LOW:
                    rdata_d = {hsdiv_q, mval_q};
                OFS_OUTPUT_CLOCK_CONTROL_HIGH:
                    rdata_d = nval_q;
                default:
                    rdata_d = BYTE_ZERO;
            endcase
        end
        act_d = mode_now;
        // Done once the strap has been latched
        done_d = (st_q == SMCC_ST_DONE);
        // Divider codes are powers of two; reserved codes pass through
        cfg_d.in_div_log2 = clkdiv_q;
        cfg_d.osc_range = osc_q;
        // Oscillator in internal-clock mode or with no external clock
        cfg_d.use_osc = (mode_now == SMCC_MODE_NSYNC_INT) || !EXT_CLK_DETECTED;
        cfg_d.hs_div_log2 = {2'b00, hsdiv_q};   // Divide by 2**code
        cfg_d.m_val = mval_q;
        cfg_d.n_val = nval_q;
        cfg_d.out_clk_en = (mval_q != 5'h00);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            rdata_q <= BYTE_ZERO;
            rvalid_q <= 1'b0;
            act_q <= 3'h0;
            done_q <= 1'b0;
            cfg_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            act_q <= act_d;
            done_q <= done_d;
            cfg_q <= cfg_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign ACTIVE_MODE = act_q;
    assign MODE_DONE = done_q;
    assign RAW10_PARALLEL_MODE_BIT = raw10_q;
    assign RAW12_PARALLEL_MODE_BIT = raw12_q;
    assign CLK_CFG = cfg_q;

    // ==========================================================
    // Assertions
    a_strap_capture: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_q == SMCC_ST_DOWN && POWERDOWN_ACTIVE_LOW_PIN_N && !pdb_q && !ov_q)
        |-> ##2 ACTIVE_MODE == $past(MODE_STRAP, 2)) else $error("strap not captured");
    a_done_after_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_q == SMCC_ST_LATCH) |-> ##2 MODE_DONE) else $error("done late");
    a_mode_locked: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!ov_q && !$rose(st_q == SMCC_ST_LATCH)) |=> $stable(strap_q) || st_q == SMCC_ST_LATCH)
        else $error("strap moved");
    a_override_mode: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ov_q |=> ACTIVE_MODE == $past(regmode_q)) else $error("override ignored");
    a_protect_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (prot_q && !(REG_WR && REG_ADDR == OFS_PARALLEL_MODE_SELECT)) |=> $stable(raw10_q) && $stable(raw12_q))
        else $error("protected bits changed");
    a_chan_load: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (CHAN_RX_LOCK && !prot_q && !REG_WR) |=> raw10_q == $past(CHAN_RAW10) && raw12_q == $past(CHAN_RAW12))
        else $error("channel load missed");
    a_m_zero_stop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (mval_q == 5'h00) |=> !CLK_CFG.out_clk_en) else $error("clock not stopped");
    a_osc_select: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !EXT_CLK_DETECTED |=> CLK_CFG.use_osc) else $error("oscillator not used");
    c_strap: cover property (@(posedge REF_CLK) st_q == SMCC_ST_LATCH);
    c_override: cover property (@(posedge REF_CLK) ov_q && REG_WR && REG_ADDR == OFS_OPERATING_MODE_SELECT);
    c_autoload: cover property (@(posedge REF_CLK) CHAN_RX_LOCK && !prot_q && CHAN_RAW10);
endmodule

/* tb/smcc_host_model.sv */
// Register host model standing in for the local I2C target and the control channel.
// Assumes byte strobes already decoded from the serial bus; drives only at falling edges.
module smcc_host_model (
    // Clock
    input wire logic clk,
    // Register port towards the block
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Idle bus
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // ==========================================================
    // One-cycle write strobe; released lines flip so stale values never match
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // One-cycle read strobe; waits a bounded time for the valid pulse
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        // Missing valid pulse yields unknown data, so the compare fails
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

/* tb/smcc_tb_top.sv */
// Self-checking bench for the mode and clock configuration register group.
// Assumes the host model for register traffic; pins and channel driven here at falling edges.
module smcc_tb_top
    import smcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, sys_rst, pin_n, ext_clk, lock, c10, c12;
    logic [2:0] strap, active_mode;
    logic wr, rd, rvalid, done, raw10, raw12;
    logic [7:0] addr, wdata, rdata;
    smcc_clkcfg_s cfg;
    int num_errors = 0;
    int cmp_count = 0;
    // ==========================================================
    // Design and host
    smcc_top uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .POWERDOWN_ACTIVE_LOW_PIN_N(pin_n),
        .MODE_STRAP(strap), .EXT_CLK_DETECTED(ext_clk), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CHAN_RX_LOCK(lock),
        .CHAN_RAW10(c10), .CHAN_RAW12(c12), .ACTIVE_MODE(active_mode), .MODE_DONE(done),
        .RAW10_PARALLEL_MODE_BIT(raw10), .RAW12_PARALLEL_MODE_BIT(raw12), .CLK_CFG(cfg));
    smcc_host_model host (.clk(ref_clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    // ==========================================================
    // Clock at 50 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // Compare helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    // Registered outputs settle within three cycles of a write
    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rchk(OFS_PARALLEL_MODE_SELECT, 8'h00);
        rchk(OFS_REFERENCE_CLOCK_CONTROL, 8'h03);
        rchk(OFS_OUTPUT_CLOCK_CONTROL_LOW, 8'h41);
        rchk(OFS_OUTPUT_CLOCK_CONTROL_HIGH, 8'h28);
        chk("done", 8'h00, 8'(done));
        $display("Test reset values done");
    endtask
    // Power-down cycle latches a new strap
    task automatic t_strap(input logic [2:0] s);
        pin_n = 1'b0;
        strap = s;
        settle();
        chk("done low", 8'h00, 8'(done));
        pin_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk("done high", 8'h01, 8'(done));
        chk("mode", 8'(s), 8'(active_mode));
        rchk(OFS_OPERATING_MODE_SELECT, 8'h08 | 8'(s));
        $display("Test strap capture done");
    endtask
    task automatic t_override();
        logic [2:0] m;
        logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};   // Every defined mode code, reserved ones left out
        host.write(OFS_OPERATING_MODE_SELECT, 8'h03);
        rchk(OFS_OPERATING_MODE_SELECT, 8'h0A);
        // Setting override alone keeps the strapped value
        host.write(OFS_OPERATING_MODE_SELECT, 8'h13);
        rchk(OFS_OPERATING_MODE_SELECT, 8'h1A);
        foreach (modes[i])
        begin
            m = modes[i];
            host.write(OFS_OPERATING_MODE_SELECT, 8'h10 | 8'(m));
            settle();
            chk("ov mode", 8'(m), 8'(active_mode));
            chk("use osc", 8'(m == 3'h3), 8'(cfg.use_osc));
            rchk(OFS_OPERATING_MODE_SELECT, 8'h18 | 8'(m));
        end
        ext_clk = 1'b0;
        settle();
        chk("osc no ext", 8'h01, 8'(cfg.use_osc));
        ext_clk = 1'b1;
        host.write(OFS_OPERATING_MODE_SELECT, 8'h00);
        settle();
        chk("back to strap", 8'h02, 8'(active_mode));
        $display("Test override done");
    endtask
    task automatic t_channel();
        c10 = 1'b1;
        c12 = 1'b0;
        settle();
        chk("no lock", 8'h00, 8'(raw10));
        lock = 1'b1;
        settle();
        chk("raw10 load", 8'h01, 8'(raw10));
        rchk(OFS_PARALLEL_MODE_SELECT, 8'h04);
        c10 = 1'b0;
        c12 = 1'b1;
        settle();
        chk("raw12 load", 8'h02, {6'h00, raw12, raw10});
        host.write(OFS_PARALLEL_MODE_SELECT, 8'h05);
        settle();
        chk("protected", 8'h01, {6'h00, raw12, raw10});
        rchk(OFS_PARALLEL_MODE_SELECT, 8'h05);
        lock = 1'b0;
        $display("Test channel done");
    endtask
    task automatic t_clock();
        logic [4:0] m;
        for (int c = 0; c < 4; c++)
        begin
            host.write(OFS_REFERENCE_CLOCK_CONTROL, 8'((c << 4) | ((c & 1) << 3) | 3));
            settle();
            chk("in div", 8'(c), 8'(cfg.in_div_log2));
            chk("osc range", 8'(c & 1), 8'(cfg.osc_range));
        end
        for (int h = 0; h < 5; h++)
        begin
            m = (h == 4) ? 5'h1F : 5'(h * 7);
            host.write(OFS_OUTPUT_CLOCK_CONTROL_LOW, 8'((h << 5) | m));
            settle();
            chk("hs div", 8'(h), 8'(cfg.hs_div_log2));
            chk("m val", 8'(m), 8'(cfg.m_val));
            chk("out en", 8'(m != 5'h00), 8'(cfg.out_clk_en));
        end
        host.write(OFS_OUTPUT_CLOCK_CONTROL_HIGH, 8'h01);
        settle();
        chk("n val", 8'h01, cfg.n_val);
        host.write(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        $display("Test clock control done");
    endtask
    // ==========================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        results();
    end
    // ==========================================================
    // Main sequence; pin held low through reset so capture is explicit
    initial
    begin
        sys_rst = 1'b1;
        pin_n = 1'b0;
        strap = 3'h2;
        ext_clk = 1'b1;
        lock = 1'b0;
        c10 = 1'b0;
        c12 = 1'b0;
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_strap(3'h2);
        t_override();
        t_strap(3'h5);
        t_channel();
        t_clock();
        results();
    end
endmodule
